// File: design/parity_err_pkg.sv
// Constants for the bridge parity checking and error reporting block.
// Assumes an APB master with 32-bit data and byte addresses.
package parity_err_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PSTAT_OFS = 8'h04;
  localparam logic [7:0] SSTAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // Control register
  localparam int CTRL_P_RESP_BIT = 0;
  localparam int CTRL_SERR_EN_BIT = 1;
  localparam int CTRL_S_RESP_BIT = 2;
  // Status registers, secondary has no system error bit
  localparam int STAT_DET_BIT = 0;
  localparam int STAT_SIG_SERR_BIT = 1;
  localparam int STAT_DPD_BIT = 2;
  // Interrupt events
  localparam int IRQ_P_ADDR_BIT = 0;
  localparam int IRQ_S_ADDR_BIT = 1;
  localparam int IRQ_P_DATA_BIT = 2;
  localparam int IRQ_S_DATA_BIT = 3;
  localparam int IRQ_W = 4;

  // ****************************************************************
  // Reset values and bus indices
  // ****************************************************************
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam int PRI = 0;
  localparam int SEC = 1;

endpackage : parity_err_pkg

// File: design/bridge_parity_error_handler.sv
// Parity check, parity generation and error signalling for both bus sides
// of a transparent two-interface bridge, with an APB register slave.
// Assumes bus phase strobes are decoded elsewhere, synchronous to core_clk_in.
//
// Operation
// - Check, generate and forward parity on both buses.
// - Check address parity of every transaction.
// - Primary address error with response set: no claim.
// - Primary address error sets primary detected bit.
// - Primary address error raises system error when enabled and response set.
// - Secondary address error: no claim with response set, always set detected bit.
// - Secondary address error raises primary system error when enabled and secondary response set.
// - Pass data parity condition across unchanged.
// - Own config write error: ready, store, parity error with response set.
// - Own config write error always sets detected bit.
// - Downstream read error: secondary parity error with response set, two cycles.
// - Downstream read error sets secondary status bits.
// - Upstream read error: primary parity error with response set, two cycles.
// - Upstream read error sets primary status bits.
// - Return read data with received parity.
// - Initiator parity error while returning data: no action.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module bridge_parity_error_handler (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Primary bus observation
  input wire logic [31:0] p_ad_in,
  input wire logic [3:0] p_cbe_in,
  input wire logic p_par_in,
  input wire logic p_addr_phase_in,
  input wire logic p_target_hit_in,
  input wire logic p_data_xfer_in,
  input wire logic p_read_xfer_in,
  input wire logic p_cfg_write_in,
  input wire logic p_done_in,
  input wire logic p_drive_in,
  input wire logic p_drive_bad_in,
  // Secondary bus observation
  input wire logic [31:0] s_ad_in,
  input wire logic [3:0] s_cbe_in,
  input wire logic s_par_in,
  input wire logic s_addr_phase_in,
  input wire logic s_target_hit_in,
  input wire logic s_data_xfer_in,
  input wire logic s_read_xfer_in,
  input wire logic s_done_in,
  input wire logic s_drive_in,
  input wire logic s_drive_bad_in,
  // Primary pins
  output logic primary_device_select_n_out,
  output logic primary_device_select_oe_out,
  output logic primary_target_ready_n_out,
  output logic primary_target_ready_oe_out,
  output logic primary_parity_error_n_out,
  output logic primary_parity_error_oe_out,
  output logic primary_system_error_n_out,
  output logic primary_system_error_oe_out,
  output logic p_par_out,
  output logic p_par_oe_out,
  // Secondary pins
  output logic secondary_device_select_n_out,
  output logic secondary_device_select_oe_out,
  output logic secondary_parity_error_n_out,
  output logic secondary_parity_error_oe_out,
  output logic s_par_out,
  output logic s_par_oe_out,
  // Datapath side
  output logic p_data_bad_out,
  output logic s_data_bad_out,
  output logic cfg_store_out,
  output logic irq_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] ph_addr;
    logic [1:0] ph_hit;
    logic [1:0] ph_data;
    logic [1:0] ph_rd;
    logic ph_cfg;
    logic [1:0] calc_par;
    logic [1:0] drv;
    logic [1:0] claim_n;
    logic [1:0] perr_n;
    logic [1:0] par_out;
    logic [1:0] bad_out;
    logic serr_n;
    logic trdy_n;
    logic store;
    logic [1:0] claim_oe;
    logic [1:0] perr_oe;
    logic serr_oe;
    logic trdy_oe;
    logic [2:0] ctrl;
    logic [2:0] pstat;
    logic [2:0] sstat;
    logic [3:0] irq_st;
    logic [3:0] irq_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Per-bus views of the inputs
  logic [1:0] addr_in;
  logic [1:0] hit_in;
  logic [1:0] xfer_in;
  logic [1:0] rd_in;
  logic [1:0] done_in;
  logic [1:0] drive_in;
  logic [1:0] drive_bad_in;
  logic [1:0] par_in;
  logic [1:0] line_par;
  logic [1:0] resp;
  logic [1:0] aerr;
  logic [1:0] derr;
  logic wr_acc;

  assign addr_in = {s_addr_phase_in, p_addr_phase_in};
  assign hit_in = {s_target_hit_in, p_target_hit_in};
  // Own config transfer is a primary data phase as well
  assign xfer_in = {s_data_xfer_in, p_data_xfer_in | ~st_r.trdy_n};
  assign rd_in = {s_read_xfer_in, p_read_xfer_in};
  assign done_in = {s_done_in, p_done_in};
  assign drive_in = {s_drive_in, p_drive_in};
  assign drive_bad_in = {s_drive_bad_in, p_drive_bad_in};
  assign par_in = {s_par_in, p_par_in};
  // Even parity over data and command lines
  assign line_par = {^{s_ad_in, s_cbe_in}, ^{p_ad_in, p_cbe_in}};
  assign resp = {st_r.ctrl[parity_err_pkg::CTRL_S_RESP_BIT],
                 st_r.ctrl[parity_err_pkg::CTRL_P_RESP_BIT]};
  assign wr_acc = psel_in & penable_in & pwrite_in & st_r.pready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    // Parity compare, one clock after the covered phase
    for (int b = 0; b < 2; b++) begin
      aerr[b] = st_r.ph_addr[b] & (st_r.calc_par[b] ^ par_in[b]);
      derr[b] = st_r.ph_data[b] & (st_r.calc_par[b] ^ par_in[b]);
    end
    // Pipeline of phases and computed parity
    st_nxt.ph_addr = addr_in;
    st_nxt.ph_hit = hit_in;
    st_nxt.ph_data = xfer_in;
    st_nxt.ph_rd = rd_in & xfer_in;
    st_nxt.ph_cfg = ~st_r.trdy_n;
    st_nxt.calc_par = line_par;
    st_nxt.drv = drive_in;
    for (int b = 0; b < 2; b++) begin
      // Claim unless an address error must be answered
      if (st_r.ph_addr[b] && st_r.ph_hit[b] && !(aerr[b] && resp[b])) begin
        st_nxt.claim_n[b] = 1'h0;
      end else if (done_in[b]) begin
        st_nxt.claim_n[b] = 1'h1;
      end
      // Parity driven one clock after the bridge drives the lines
      st_nxt.par_out[b] = line_par[b] ^ drive_bad_in[b];
      // Bad data flag stored with the data for forwarding
      st_nxt.bad_out[b] = derr[b];
    end
    // Parity error reporting, only from own checks
    st_nxt.perr_n[0] = ~(derr[0] & (st_r.ph_rd[0] | st_r.ph_cfg) & resp[0]);
    st_nxt.perr_n[1] = ~(derr[1] & st_r.ph_rd[1] & resp[1]);
    // System error from either address error
    st_nxt.serr_n = ~(st_r.ctrl[parity_err_pkg::CTRL_SERR_EN_BIT] &
                      |(aerr & resp));
    // Own type 0 config write: one transfer cycle with data store
    st_nxt.trdy_n = ~p_cfg_write_in;
    st_nxt.store = p_cfg_write_in;
    // Output enables registered with the active levels
    st_nxt.claim_oe = ~st_nxt.claim_n;
    st_nxt.perr_oe = ~st_nxt.perr_n;
    st_nxt.serr_oe = ~st_nxt.serr_n;
    st_nxt.trdy_oe = ~st_nxt.trdy_n;
    // APB slave, one wait-free access phase
    st_nxt.pready = psel_in & ~penable_in;
    st_nxt.pslverr = 1'h0;
    st_nxt.prdata = '0;
    if (psel_in && !penable_in) begin
      unique case (paddr_in)
        parity_err_pkg::CTRL_OFS: st_nxt.prdata[2:0] = st_r.ctrl;
        parity_err_pkg::PSTAT_OFS: st_nxt.prdata[2:0] = st_r.pstat;
        parity_err_pkg::SSTAT_OFS: st_nxt.prdata[2:0] = st_r.sstat;
        parity_err_pkg::IRQ_STAT_OFS: st_nxt.prdata[3:0] = st_r.irq_st;
        parity_err_pkg::IRQ_EN_OFS: st_nxt.prdata[3:0] = st_r.irq_en;
        parity_err_pkg::IRQ_CLR_OFS: st_nxt.prdata = '0;
        default: st_nxt.pslverr = 1'h1;
      endcase
    end
    // Register writes; status clears are write-one
    if (wr_acc) begin
      unique case (paddr_in)
        parity_err_pkg::CTRL_OFS: st_nxt.ctrl = pwdata_in[2:0];
        parity_err_pkg::PSTAT_OFS: st_nxt.pstat = st_r.pstat & ~pwdata_in[2:0];
        parity_err_pkg::SSTAT_OFS: st_nxt.sstat = st_r.sstat & ~pwdata_in[2:0];
        parity_err_pkg::IRQ_CLR_OFS: st_nxt.irq_st = st_r.irq_st & ~pwdata_in[3:0];
        parity_err_pkg::IRQ_EN_OFS: st_nxt.irq_en = pwdata_in[3:0];
        default: st_nxt.irq_en = st_r.irq_en;
      endcase
    end
    // Status setting after clears, so a set wins
    if (aerr[0] || (derr[0] && (st_r.ph_rd[0] || st_r.ph_cfg))) begin
      st_nxt.pstat[parity_err_pkg::STAT_DET_BIT] = 1'h1;
    end
    if (derr[0] && st_r.ph_rd[0] && resp[0]) begin
      st_nxt.pstat[parity_err_pkg::STAT_DPD_BIT] = 1'h1;
    end
    if (!st_nxt.serr_n) begin
      st_nxt.pstat[parity_err_pkg::STAT_SIG_SERR_BIT] = 1'h1;
    end
    if (aerr[1] || (derr[1] && st_r.ph_rd[1])) begin
      st_nxt.sstat[parity_err_pkg::STAT_DET_BIT] = 1'h1;
    end
    if (derr[1] && st_r.ph_rd[1] && resp[1]) begin
      st_nxt.sstat[parity_err_pkg::STAT_DPD_BIT] = 1'h1;
    end
    // Sticky interrupt events
    st_nxt.irq_st[parity_err_pkg::IRQ_P_ADDR_BIT] =
      st_nxt.irq_st[parity_err_pkg::IRQ_P_ADDR_BIT] | aerr[0];
    st_nxt.irq_st[parity_err_pkg::IRQ_S_ADDR_BIT] =
      st_nxt.irq_st[parity_err_pkg::IRQ_S_ADDR_BIT] | aerr[1];
    st_nxt.irq_st[parity_err_pkg::IRQ_P_DATA_BIT] =
      st_nxt.irq_st[parity_err_pkg::IRQ_P_DATA_BIT] | derr[0];
    st_nxt.irq_st[parity_err_pkg::IRQ_S_DATA_BIT] =
      st_nxt.irq_st[parity_err_pkg::IRQ_S_DATA_BIT] | derr[1];
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_en);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.claim_n <= 2'h3;
      st_r.perr_n <= 2'h3;
      st_r.serr_n <= 1'h1;
      st_r.trdy_n <= 1'h1;
      st_r.ctrl <= parity_err_pkg::CTRL_RST;
      st_r.pstat <= parity_err_pkg::STAT_RST;
      st_r.sstat <= parity_err_pkg::STAT_RST;
      st_r.irq_st <= parity_err_pkg::IRQ_RST;
      st_r.irq_en <= parity_err_pkg::IRQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Enables follow the active level of each flop
  assign prdata_out = st_r.prdata;
  assign pready_out = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign primary_device_select_n_out = st_r.claim_n[0];
  assign primary_device_select_oe_out = st_r.claim_oe[0];
  assign secondary_device_select_n_out = st_r.claim_n[1];
  assign secondary_device_select_oe_out = st_r.claim_oe[1];
  assign primary_target_ready_n_out = st_r.trdy_n;
  assign primary_target_ready_oe_out = st_r.trdy_oe;
  assign primary_parity_error_n_out = st_r.perr_n[0];
  assign primary_parity_error_oe_out = st_r.perr_oe[0];
  assign secondary_parity_error_n_out = st_r.perr_n[1];
  assign secondary_parity_error_oe_out = st_r.perr_oe[1];
  assign primary_system_error_n_out = st_r.serr_n;
  assign primary_system_error_oe_out = st_r.serr_oe;
  assign p_par_out = st_r.par_out[0];
  assign p_par_oe_out = st_r.drv[0];
  assign s_par_out = st_r.par_out[1];
  assign s_par_oe_out = st_r.drv[1];
  assign p_data_bad_out = st_r.bad_out[0];
  assign s_data_bad_out = st_r.bad_out[1];
  assign cfg_store_out = st_r.store;
  assign irq_out = st_r.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pri_addr_det;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      aerr[0] |=> st_r.pstat[parity_err_pkg::STAT_DET_BIT];
  endproperty
  a_pri_addr_det: assert property (p_pri_addr_det)
    else $error("primary address error did not set detected bit");

  property p_pri_no_claim;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (aerr[0] && resp[0]) |=> primary_device_select_n_out;
  endproperty
  a_pri_no_claim: assert property (p_pri_no_claim)
    else $error("primary claimed despite address error");

  property p_sec_no_claim;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (aerr[1] && resp[1]) |=> secondary_device_select_n_out;
  endproperty
  a_sec_no_claim: assert property (p_sec_no_claim)
    else $error("secondary claimed despite address error");

  property p_serr_cause;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      $fell(primary_system_error_n_out) |->
        ($past(st_r.ph_addr[0], 1) || $past(st_r.ph_addr[1], 1)) &&
        $past(st_r.ctrl[parity_err_pkg::CTRL_SERR_EN_BIT], 1);
  endproperty
  a_serr_cause: assert property (p_serr_cause)
    else $error("system error without enabled address error");

  property p_sec_serr;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (aerr[1] && resp[1] && st_r.ctrl[parity_err_pkg::CTRL_SERR_EN_BIT]) |=>
        !primary_system_error_n_out &&
        st_r.pstat[parity_err_pkg::STAT_SIG_SERR_BIT];
  endproperty
  a_sec_serr: assert property (p_sec_serr)
    else $error("secondary address error not signalled");

  property p_cfg_ready;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      p_cfg_write_in |=> !primary_target_ready_n_out && cfg_store_out;
  endproperty
  a_cfg_ready: assert property (p_cfg_ready)
    else $error("config write not accepted and stored");

  property p_sec_perr_time;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      !secondary_parity_error_n_out |-> $past(s_data_xfer_in, 2) && $past(s_read_xfer_in, 2);
  endproperty
  a_sec_perr_time: assert property (p_sec_perr_time)
    else $error("secondary parity error not two cycles after read transfer");

  property p_pri_perr_time;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      !primary_parity_error_n_out |->
        $past(xfer_in[0], 2) && $past(resp[0], 1);
  endproperty
  a_pri_perr_time: assert property (p_pri_perr_time)
    else $error("primary parity error timing or enable wrong");

  property p_par_gen;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      p_drive_in |=> p_par_oe_out &&
        (p_par_out == ($past(line_par[0], 1) ^ $past(p_drive_bad_in, 1)));
  endproperty
  a_par_gen: assert property (p_par_gen)
    else $error("generated primary parity wrong");

  property p_sec_par_gen;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      s_drive_in |=> s_par_oe_out &&
        (s_par_out == ($past(line_par[1], 1) ^ $past(s_drive_bad_in, 1)));
  endproperty
  a_sec_par_gen: assert property (p_sec_par_gen)
    else $error("generated secondary parity wrong");

endmodule : bridge_parity_error_handler

// File: tb/bus_agent_model.sv
// Behavioural bus agent for one side of the bridge: lines and phase strobes.
// Assumes the bench calls phase() from its main sequence, on clk_in.
`timescale 1ns/1ps
module bus_agent_model (
  // Clock
  input wire logic clk_in,
  // Bus lines and phase strobes
  output logic [31:0] ad_out,
  output logic [3:0] cbe_out,
  output logic par_out,
  output logic adr_out,
  output logic hit_out,
  output logic xfr_out,
  output logic rd_out,
  output logic cfg_out,
  output logic done_out,
  output logic drv_out,
  output logic bad_out,
  // Initiator parity report
  output logic perr_n_out
);
  logic bad_r;
  logic rd_bad_r;

  // Idle levels at time zero
  initial begin
    {ad_out, cbe_out, par_out, adr_out, hit_out, xfr_out} = '0;
    {rd_out, cfg_out, done_out, drv_out, bad_out, bad_r, rd_bad_r} = '0;
    perr_n_out = 1'b1;
  end

  // Initiator flags bad read data two cycles after the transfer
  always @(posedge clk_in) begin
    rd_bad_r <= xfr_out & rd_out & bad_r;
    perr_n_out <= ~rd_bad_r;
  end

  // Even parity one clock after the phase, flipped on request
  always @(posedge clk_in) begin
    par_out <= ^{ad_out, cbe_out, bad_r};
  end

  // *******************************************************************
  // Kinds: 0 address, 1 data, 2 config write, 3 bridge drive, 4 end
  // *******************************************************************
  task automatic phase(input int k, input logic h, input logic r, input logic bad,
                       input logic [31:0] v);
    @(posedge clk_in);
    ad_out <= v;
    cbe_out <= v[3:0];
    adr_out <= (k == 0);
    hit_out <= h & (k == 0);
    xfr_out <= (k == 1);
    rd_out <= r & (k == 1);
    cfg_out <= (k == 2);
    drv_out <= (k == 3);
    bad_out <= bad & (k == 3);
    done_out <= (k == 4);
    bad_r <= bad & (k != 3);
    @(posedge clk_in);
    {adr_out, hit_out, xfr_out, rd_out, cfg_out, drv_out, bad_out, done_out} <= '0;
    // Config data stays one more cycle, then the lines are let go
    if (k == 2) @(posedge clk_in);
    ad_out <= ~v;
    bad_r <= 1'b0;
  endtask : phase
endmodule : bus_agent_model

// File: tb/tb_top.sv
// Self-checking bench for the bridge parity error handler.
// Assumes bus agent models on both sides and an APB master in the bench.
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, p_ad_in, s_ad_in, v;
  logic [3:0] p_cbe_in, s_cbe_in;
  logic p_par_in, p_addr_phase_in, p_target_hit_in, p_data_xfer_in, p_read_xfer_in;
  logic p_cfg_write_in, p_done_in, p_drive_in, p_drive_bad_in, s_par_in, s_addr_phase_in;
  logic s_target_hit_in, s_data_xfer_in, s_read_xfer_in, s_done_in, s_drive_in, s_drive_bad_in;
  logic primary_device_select_n_out, primary_device_select_oe_out;
  logic primary_target_ready_n_out, primary_target_ready_oe_out;
  logic primary_parity_error_n_out, primary_parity_error_oe_out;
  logic primary_system_error_n_out, primary_system_error_oe_out, p_par_out, p_par_oe_out;
  logic secondary_device_select_n_out, secondary_device_select_oe_out;
  logic secondary_parity_error_n_out, secondary_parity_error_oe_out, s_par_out, s_par_oe_out;
  logic p_data_bad_out, s_data_bad_out, cfg_store_out, irq_out;
  int error_cnt, tests_run;

  // Design and the two bus agents
  bridge_parity_error_handler dut (.core_clk_in, .reset_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .p_ad_in,
    .p_cbe_in, .p_par_in, .p_addr_phase_in, .p_target_hit_in, .p_data_xfer_in,
    .p_read_xfer_in, .p_cfg_write_in, .p_done_in, .p_drive_in, .p_drive_bad_in, .s_ad_in,
    .s_cbe_in, .s_par_in, .s_addr_phase_in, .s_target_hit_in, .s_data_xfer_in,
    .s_read_xfer_in, .s_done_in, .s_drive_in, .s_drive_bad_in,
    .primary_device_select_n_out, .primary_device_select_oe_out,
    .primary_target_ready_n_out, .primary_target_ready_oe_out, .primary_parity_error_n_out,
    .primary_parity_error_oe_out, .primary_system_error_n_out, .primary_system_error_oe_out,
    .p_par_out, .p_par_oe_out, .secondary_device_select_n_out,
    .secondary_device_select_oe_out, .secondary_parity_error_n_out,
    .secondary_parity_error_oe_out, .s_par_out, .s_par_oe_out, .p_data_bad_out,
    .s_data_bad_out, .cfg_store_out, .irq_out);
  bus_agent_model pa (.clk_in(core_clk_in), .ad_out(p_ad_in), .cbe_out(p_cbe_in),
    .par_out(p_par_in), .adr_out(p_addr_phase_in), .hit_out(p_target_hit_in),
    .xfr_out(p_data_xfer_in), .rd_out(p_read_xfer_in), .cfg_out(p_cfg_write_in),
    .done_out(p_done_in), .drv_out(p_drive_in), .bad_out(p_drive_bad_in), .perr_n_out());
  bus_agent_model sa (.clk_in(core_clk_in), .ad_out(s_ad_in), .cbe_out(s_cbe_in),
    .par_out(s_par_in), .adr_out(s_addr_phase_in), .hit_out(s_target_hit_in),
    .xfr_out(s_data_xfer_in), .rd_out(s_read_xfer_in), .cfg_out(),
    .done_out(s_done_in), .drv_out(s_drive_in), .bad_out(s_drive_bad_in), .perr_n_out());

  // 50 MHz clock
  always #10 core_clk_in = ~core_clk_in;

  // *******************************************************************
  // Compare, bus and scenario tasks
  // *******************************************************************
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, input logic e, input string m);
    chk_w({31'h0, g}, {31'h0, e}, m);
  endtask : chk_b
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1);
    chk_b(n == 1, 1'b1, "ready latency");
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk_w(q & m, x, "read data");
    chk_b(e, a > 8'h14, "slave error");
  endtask : rd
  task automatic clean();
    wr(parity_err_pkg::PSTAT_OFS, 32'h7);
    wr(parity_err_pkg::SSTAT_OFS, 32'h7);
    wr(parity_err_pkg::IRQ_CLR_OFS, 32'hF);
  endtask : clean
  task automatic agent(input int b, input int k, input logic r, input logic bad);
    if (b == parity_err_pkg::SEC) sa.phase(k, 1'b1, r, bad, 32'h1234_5678);
    else pa.phase(k, 1'b1, r, bad, 32'hA5C3_0F96);
  endtask : agent
  // Address phase: claim, system error, status and interrupt status
  task automatic acase(input int b, input logic [2:0] c, input logic bad, input logic dv,
                       input logic se, input logic [31:0] ps, input logic [31:0] ss);
    wr(parity_err_pkg::CTRL_OFS, {29'h0, c});
    agent(b, 0, 1'b0, bad);
    @(posedge core_clk_in);
    #1;
    chk_b(b ? secondary_device_select_n_out : primary_device_select_n_out, dv, "claim");
    chk_b(primary_system_error_n_out, se, "system error");
    chk_b(b ? secondary_device_select_oe_out : primary_device_select_oe_out, ~dv,
          "claim drive");
    chk_b(primary_system_error_oe_out, ~se, "system error drive");
    agent(b, 4, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk_b(b ? secondary_device_select_n_out : primary_device_select_n_out, 1'b1, "release");
    rd(parity_err_pkg::PSTAT_OFS, ps);
    rd(parity_err_pkg::SSTAT_OFS, ss);
    rd(parity_err_pkg::IRQ_STAT_OFS, {31'h0, bad} << b);
    clean();
  endtask : acase
  // Read data phase: parity error pulse two cycles on, flag and status
  task automatic dcase(input int b, input logic [2:0] c, input logic bad, input logic pe,
                       input logic [31:0] st);
    wr(parity_err_pkg::CTRL_OFS, {29'h0, c});
    agent(b, 1, 1'b1, bad);
    @(posedge core_clk_in);
    #1;
    chk_b(b ? secondary_parity_error_n_out : primary_parity_error_n_out, pe, "parity error");
    chk_b(b ? secondary_parity_error_oe_out : primary_parity_error_oe_out, ~pe,
          "parity error drive");
    chk_b(b ? s_data_bad_out : p_data_bad_out, bad, "bad flag");
    rd(b ? parity_err_pkg::SSTAT_OFS : parity_err_pkg::PSTAT_OFS, st);
    clean();
  endtask : dcase
  task automatic results();
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (6000) @(posedge core_clk_in);
    $display("[FAIL] %0t watchdog", $time);
    error_cnt++;
    results();
  end

  // *******************************************************************
  // Main sequence
  // *******************************************************************
  initial begin
    {core_clk_in, reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk_b(primary_system_error_n_out, 1'b1, "reset level");
    for (int a = 0; a < 28; a += 4) rd(a[7:0], 32'h0);
    wr(parity_err_pkg::IRQ_STAT_OFS, 32'hF);
    rd(parity_err_pkg::IRQ_STAT_OFS, 32'h0);
    acase(0, 3'h3, 1'b1, 1'b1, 1'b0, 32'h3, 32'h0);
    acase(0, 3'h6, 1'b1, 1'b0, 1'b1, 32'h1, 32'h0);
    acase(0, 3'h3, 1'b0, 1'b0, 1'b1, 32'h0, 32'h0);
    acase(1, 3'h6, 1'b1, 1'b1, 1'b0, 32'h2, 32'h1);
    acase(1, 3'h2, 1'b1, 1'b0, 1'b1, 32'h0, 32'h1);
    acase(1, 3'h5, 1'b1, 1'b1, 1'b1, 32'h0, 32'h1);
    dcase(1, 3'h4, 1'b1, 1'b0, 32'h5);
    dcase(1, 3'h3, 1'b1, 1'b1, 32'h1);
    dcase(0, 3'h1, 1'b1, 1'b0, 32'h5);
    dcase(0, 3'h4, 1'b1, 1'b1, 32'h1);
    dcase(0, 3'h1, 1'b0, 1'b1, 32'h0);
    // Own config write with bad data parity, response on and off
    for (int i = 0; i < 2; i++) begin
      wr(parity_err_pkg::CTRL_OFS, i);
      fork
        pa.phase(2, 1'b0, 1'b0, 1'b1, 32'h0000_00F1);
        begin
          repeat (2) @(posedge core_clk_in);
          #1;
          chk_b(primary_target_ready_n_out, 1'b0, "ready");
          chk_b(cfg_store_out, 1'b1, "store");
          chk_b(primary_target_ready_oe_out, 1'b1, "ready drive");
        end
      join
      @(posedge core_clk_in);
      #1;
      chk_b(primary_parity_error_n_out, ~i[0], "cfg parity error");
      rd(parity_err_pkg::PSTAT_OFS, 32'h1, 32'h1);
      clean();
    end
    // Generated parity on both buses, good and forwarded bad
    for (int i = 0; i < 4; i++) begin
      v = (i / 2) ? 32'h1234_5678 : 32'hA5C3_0F96;
      agent(i / 2, 3, 1'b0, i[0]);
      #1;
      chk_b((i / 2) ? s_par_out : p_par_out, ^{v, v[3:0], i[0]}, "parity out");
      chk_b((i / 2) ? s_par_oe_out : p_par_oe_out, 1'b1, "parity drive");
    end
    // Interrupt raised, masked, enabled and cleared
    wr(parity_err_pkg::IRQ_EN_OFS, 32'h0);
    agent(0, 1, 1'b1, 1'b1);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk_b(irq_out, 1'b0, "masked irq");
    rd(parity_err_pkg::IRQ_STAT_OFS, 32'h1 << parity_err_pkg::IRQ_P_DATA_BIT);
    wr(parity_err_pkg::IRQ_EN_OFS, 32'h1 << parity_err_pkg::IRQ_P_DATA_BIT);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_b(irq_out, 1'b1, "irq high");
    wr(parity_err_pkg::IRQ_CLR_OFS, 32'hF);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_b(irq_out, 1'b0, "irq cleared");
    rd(parity_err_pkg::IRQ_EN_OFS, 32'h4);
    results();
  end
endmodule : tb_top
